// ==== rtl/scd_pkg.sv ====
// package: constants, offsets and types for the card command decoder
package scd_pkg;
  // register byte offsets on the avalon slave
  localparam logic [5:0] ADR_HEADER   = 6'h00;
  localparam logic [5:0] ADR_LENGTH   = 6'h04;
  localparam logic [5:0] ADR_DECODE   = 6'h08;
  localparam logic [5:0] ADR_OFFSET   = 6'h0c;
  localparam logic [5:0] ADR_FILE_ID  = 6'h10;
  localparam logic [5:0] ADR_FILE_ATR = 6'h14;
  localparam logic [5:0] ADR_ACCESS   = 6'h18;
  localparam logic [5:0] ADR_DIR_INFO = 6'h1c;
  localparam logic [5:0] ADR_CODE_ST  = 6'h20;
  localparam logic [5:0] ADR_RESP     = 6'h24;
  localparam logic [5:0] ADR_SEL_DATA = 6'h28;
  // class and instruction codes
  localparam logic [7:0] CLA_APP      = 8'ha0;
  localparam logic [7:0] INS_SELECT   = 8'ha4;
  localparam logic [7:0] INS_STATUS   = 8'hf2;
  localparam logic [7:0] INS_RD_BIN   = 8'hb0;
  localparam logic [7:0] INS_UP_BIN   = 8'hd6;
  localparam logic [7:0] INS_RD_REC   = 8'hb2;
  localparam logic [7:0] INS_UP_REC   = 8'hdc;
  localparam logic [7:0] INS_SEEK     = 8'ha2;
  localparam logic [7:0] INS_INCREASE = 8'h32;
  localparam logic [7:0] INS_VERIFY   = 8'h20;
  localparam logic [7:0] INS_CHANGE   = 8'h24;
  localparam logic [7:0] INS_DISABLE  = 8'h26;
  localparam logic [7:0] INS_ENABLE   = 8'h28;
  localparam logic [7:0] INS_UNBLOCK  = 8'h2c;
  localparam logic [7:0] INS_INVAL    = 8'h04;
  localparam logic [7:0] INS_REHAB    = 8'h44;
  localparam logic [7:0] INS_AUTH     = 8'h88;
  localparam logic [7:0] INS_SLEEP    = 8'hfa;
  localparam logic [7:0] INS_GET_RSP  = 8'hc0;
  localparam logic [7:0] INS_TPROFILE = 8'h10;
  localparam logic [7:0] INS_ENVELOPE = 8'hc2;
  localparam logic [7:0] INS_FETCH    = 8'h12;
  localparam logic [7:0] INS_TRESP    = 8'h14;
  // fixed lengths and code selectors
  localparam logic [7:0] LEN_SELECT   = 8'h02;
  localparam logic [7:0] LEN_INCREASE = 8'h03;
  localparam logic [7:0] LEN_AUTH     = 8'h10;
  localparam logic [7:0] UNBLK_CODE1  = 8'h00;
  localparam logic [7:0] UNBLK_CODE2  = 8'h02;
  localparam logic [7:0] CODE2_SEL    = 8'h02;
  localparam logic [8:0] LEN_FULL     = 9'h100;
  // response record lengths in bytes
  localparam logic [4:0] DIR_RSP_LEN  = 5'h16;
  localparam logic [4:0] EF_RSP_LEN   = 5'h0f;
  localparam logic [7:0] DIR_FOLLOW   = 8'h09;
  localparam logic [7:0] EF_FOLLOW    = 8'h02;
  // bit positions inside response bytes
  localparam int CLK_PERMIT_POS = 0;
  localparam int CLK_HIGH_POS   = 2;
  localparam int CLK_LOW_POS    = 3;
  localparam int INCR_OK_POS    = 6;
  // file kinds and structure byte codes
  typedef enum logic [1:0] {
    KIND_DIR = 2'h0, KIND_TRANSP = 2'h1, KIND_LINEAR = 2'h2, KIND_CYCLIC = 2'h3
  } scd_kind_t;
  localparam logic [7:0] STRUCT_TRANSP = 8'h00;
  localparam logic [7:0] STRUCT_LINEAR = 8'h01;
  localparam logic [7:0] STRUCT_CYCLIC = 8'h03;
  // data direction as seen from the card
  typedef enum logic [1:0] {
    XFER_NONE = 2'h0, XFER_IN = 2'h1, XFER_OUT = 2'h2, XFER_BOTH = 2'h3
  } scd_dir_t;
endpackage

// ==== rtl/scd_rsp_build.sv ====
// response builder: one byte of the select or status record per index
`timescale 1ns/10ps
module scd_rsp_build
  import scd_pkg::*;
(
  scd_rsp_if.builder rsp
);
  logic [15:0] rec_size;  // record length times record count
  logic [7:0]  chr;       // file characteristics byte

  // record files report record length times count, transparent the body
  // operands widened first so the product keeps all sixteen bits
  assign rec_size = {8'h00, rsp.attr[15:8]} * {8'h00, rsp.attr[23:16]}; // RULE15
  // clock-stop condition bits sit in the characteristics byte
  always_comb begin
    chr = rsp.dir_info[31:24];
    chr[CLK_PERMIT_POS] = rsp.attr[0]; // RULE11
    chr[CLK_HIGH_POS]   = rsp.attr[1];
    chr[CLK_LOW_POS]    = rsp.attr[2];
  end

  // byte map; index 0 is response byte 1
  always_comb begin
    rsp.data = 8'h00;
    if (rsp.dir_fmt) begin
      case (rsp.idx) // RULE8 RULE9
        5'd2:    rsp.data = rsp.size[15:8];
        5'd3:    rsp.data = rsp.size[7:0];
        5'd4:    rsp.data = rsp.file_id[15:8];
        5'd5:    rsp.data = rsp.file_id[7:0];
        5'd6:    rsp.data = rsp.attr[31:24];
        5'd12:   rsp.data = DIR_FOLLOW;
        5'd13:   rsp.data = chr;
        5'd14:   rsp.data = rsp.dir_info[7:0];
        5'd15:   rsp.data = rsp.dir_info[15:8];
        5'd16:   rsp.data = rsp.dir_info[23:16];
        5'd18:   rsp.data = rsp.codes[31:24];
        5'd19:   rsp.data = rsp.codes[23:16];
        5'd20:   rsp.data = rsp.codes[15:8];
        5'd21:   rsp.data = rsp.codes[7:0];
        default: rsp.data = 8'h00; // reserved bytes read zero
      endcase
    end else begin
      case (rsp.idx) // RULE14
        5'd2:    rsp.data = (rsp.kind == KIND_TRANSP) ? rsp.size[15:8] : rec_size[15:8];
        5'd3:    rsp.data = (rsp.kind == KIND_TRANSP) ? rsp.size[7:0] : rec_size[7:0];
        5'd4:    rsp.data = rsp.file_id[15:8];
        5'd5:    rsp.data = rsp.file_id[7:0];
        5'd6:    rsp.data = rsp.attr[31:24];
        // only a cyclic file reports the increase permission
        5'd7:    rsp.data = (rsp.kind == KIND_CYCLIC) ?
                            {1'b0, rsp.attr[3], 6'h00} : 8'h00; // RULE17
        5'd8:    rsp.data = rsp.access[23:16];
        5'd9:    rsp.data = rsp.access[15:8];
        5'd10:   rsp.data = rsp.access[7:0];
        5'd11:   rsp.data = rsp.access[31:24];
        5'd12:   rsp.data = EF_FOLLOW;
        5'd13:   rsp.data = (rsp.kind == KIND_CYCLIC) ? STRUCT_CYCLIC :
                            (rsp.kind == KIND_LINEAR) ? STRUCT_LINEAR : STRUCT_TRANSP;
        5'd14:   rsp.data = (rsp.kind == KIND_TRANSP) ? 8'h00 : rsp.attr[15:8]; // RULE18
        default: rsp.data = 8'h00;
      endcase
    end
  end
endmodule

// ==== rtl/scd_rsp_if.sv ====
// interface: file description and byte index between decoder and builder
`timescale 1ns/10ps
interface scd_rsp_if;
  import scd_pkg::*;
  logic      [4:0]  idx;       // zero-based response byte index
  logic             dir_fmt;   // build the directory layout
  scd_kind_t        kind;      // kind of the selected file
  logic      [15:0] file_id;   // identifier of the selected file
  logic      [15:0] size;      // free memory or body length
  logic      [31:0] attr;      // type, record geometry, clock-stop bits
  logic      [31:0] access;    // access conditions and file status
  logic      [31:0] dir_info;  // child counts, code count, characteristics
  logic      [31:0] codes;     // four secret code status bytes
  logic      [7:0]  data;      // response byte at idx
  modport builder (input idx, dir_fmt, kind, file_id, size, attr, access,
                   dir_info, codes, output data);
  modport user (output idx, dir_fmt, kind, file_id, size, attr, access,
                dir_info, codes, input data);
endinterface

// ==== rtl/scd_top.sv ====
// card command decoder top: avalon slave, instruction decode, responses
// How it works
// RULE1: binary offset is param one high, two low
// RULE2: offset zero starts at first body byte
// RULE3: codes 16 to 1E even are reserved
// RULE4: administrative codes are flagged as reserved
// RULE5: instruction byte decodes to known command
// RULE6: each command carries its fixed data direction
// RULE7: unblock picks code by 00 or 02
// RULE8: directory record fields at fixed byte positions
// RULE9: directory bytes 14 to 22 carry card data
// RULE10: directory record always returns 22 bytes
// RULE11: clock-stop bits b1 b3 b4 in characteristics
// RULE12: handset may stop either level when permitted
// RULE13: handset obeys mandatory level or never stops
// RULE14: elementary file record fields at fixed positions
// RULE15: size is body or record product
// RULE16: file record always returns 15 bytes
// RULE17: cyclic file byte 8 bit 7 allows increase
// RULE18: byte 15 record length, zero if transparent
// RULE19: status returns directory layout record
// RULE20: select takes exactly two identifier bytes
// RULE21: only class A0 changes this state
// RULE22: length zero is 256 out, none in
//
// The register offsets and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/10ps
module scd_top
  import scd_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        RST,
  input  wire logic [5:0]  ADDRESS,
  input  wire logic        READ,
  input  wire logic        WRITE,
  input  wire logic [31:0] WRITEDATA,
  output logic      [31:0] READDATA,
  output logic             WAITREQUEST
);
  // sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001, ST_SEL_RX = 4'b0010, ST_PENDING = 4'b0100, ST_OUT = 4'b1000
  } scd_state_t;

  scd_rsp_if   rsp ();             // builder connection
  scd_state_t  state_q;            // command sequencer
  logic        ack_q;              // second cycle of a bus access
  logic        req;                // any bus request
  logic        wr_go;              // write takes effect this edge
  logic        rd_go;              // read completes this edge
  logic [31:0] header_q;           // class, instruction, two params
  logic [7:0]  length_q;           // length parameter byte
  logic [31:0] file_id_q;          // size or free memory, identifier
  logic [31:0] attr_q;             // type, records, clock-stop, increase
  logic [31:0] access_q;           // access conditions and file status
  logic [31:0] dir_info_q;         // directory counters
  logic [31:0] codes_q;            // secret code status bytes
  logic [7:0]  ins_q;              // last accepted instruction
  logic        known_q;            // last instruction recognised
  logic        rsv_op_q;           // reserved operational code seen
  logic        rsv_adm_q;          // reserved administrative code seen
  logic        foreign_q;          // last header carried a foreign class
  logic        len_bad_q;          // fixed length not matched
  logic        code2_q;            // second secret code addressed
  scd_dir_t    dir_q;              // data direction of last command
  logic [8:0]  xfer_q;             // bytes to move for last command
  logic [15:0] offset_q;           // first body byte of a binary access
  logic [15:0] sel_id_q;           // identifier gathered by select
  logic        sel_cnt_q;          // one select byte already taken
  logic        dir_fmt_q;          // pending record uses directory layout
  logic [4:0]  avail_q;            // pending response length
  logic [4:0]  idx_q;              // next response byte
  logic [4:0]  end_q;              // response bytes to stream
  logic [31:0] rdata_d;            // read mux
  logic [7:0]  cla;                // header fields
  logic [7:0]  ins;
  logic [7:0]  p1;
  logic [7:0]  p2;
  logic        class_ok;           // header carries this application class
  logic        dec_known;          // combinational decode results
  logic        dec_rsv_op;
  logic        dec_rsv_adm;
  scd_dir_t    dec_dir;
  logic        dec_len_bad;
  logic [8:0]  dec_xfer;
  logic [4:0]  want;               // requested response bytes, capped

  assign cla = header_q[31:24];
  assign ins = header_q[23:16];
  assign p1  = header_q[15:8];
  assign p2  = header_q[7:0];
  assign class_ok = (cla == CLA_APP);

  // one wait cycle per access; writes and read side effects land at the ack
  assign req         = READ | WRITE;
  assign WAITREQUEST = req & ~ack_q;
  assign wr_go       = WRITE & ack_q;
  assign rd_go       = READ & ack_q;

  // ack toggles so every access takes exactly two edges
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // instruction decode: known codes, reserved ranges, direction, length
  always_comb begin
    dec_known   = 1'b1;
    dec_dir     = XFER_NONE;
    dec_len_bad = 1'b0;
    case (ins) // RULE5 RULE6
      INS_SELECT: begin
        dec_dir     = XFER_BOTH;
        dec_len_bad = (length_q != LEN_SELECT); // RULE20
      end
      INS_STATUS, INS_RD_BIN, INS_RD_REC, INS_GET_RSP, INS_FETCH: begin
        dec_dir = XFER_OUT;
      end
      INS_UP_BIN, INS_UP_REC, INS_VERIFY, INS_CHANGE, INS_DISABLE, INS_ENABLE,
      INS_UNBLOCK, INS_TPROFILE, INS_TRESP: begin
        dec_dir = XFER_IN;
      end
      INS_SEEK, INS_ENVELOPE: begin
        dec_dir = XFER_BOTH;
      end
      INS_INCREASE: begin
        dec_dir     = XFER_BOTH;
        dec_len_bad = (length_q != LEN_INCREASE);
      end
      INS_AUTH: begin
        dec_dir     = XFER_BOTH;
        dec_len_bad = (length_q != LEN_AUTH);
      end
      INS_INVAL, INS_REHAB, INS_SLEEP: begin
        dec_dir = XFER_NONE;
      end
      default: begin
        dec_known = 1'b0;
      end
    endcase
  end

  // reserved code ranges are flagged, never executed
  assign dec_rsv_op  = (ins[7:4] == 4'h1) && !ins[0] && (ins[3:0] >= 4'h6); // RULE3
  assign dec_rsv_adm = (ins == 8'h2a) || (ins == 8'hd0) || (ins == 8'hd2) ||
                       (ins == 8'hde) || (ins[7:4] == 4'hc && !ins[0] &&
                       ins[3:0] >= 4'h4 && ins[3:0] <= 4'hc) ||
                       (ins[7:4] == 4'hb && !ins[0] &&
                       ins[3:0] >= 4'h4 && ins[3:0] <= 4'hc); // RULE4

  // zero length means a full 256 bytes outward and nothing inward
  assign dec_xfer = (length_q != 8'h00) ? {1'b0, length_q} :
                    (dec_dir == XFER_OUT) ? LEN_FULL : 9'h000; // RULE22

  // bytes requested of a record, capped at what the record holds
  assign want = (dec_xfer > {4'h0, avail_q}) ? avail_q : dec_xfer[4:0];

  // software-written header, length and file description registers
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      header_q   <= 32'h0000_0000;
      length_q   <= 8'h00;
      file_id_q  <= 32'h0000_0000;
      attr_q     <= 32'h0000_0000;
      access_q   <= 32'h0000_0000;
      dir_info_q <= 32'h0000_0000;
      codes_q    <= 32'h0000_0000;
    end else if (wr_go) begin
      case (ADDRESS)
        ADR_HEADER:   header_q   <= WRITEDATA;
        ADR_LENGTH:   length_q   <= WRITEDATA[7:0];
        ADR_FILE_ID:  file_id_q  <= WRITEDATA;
        ADR_FILE_ATR: attr_q     <= WRITEDATA;
        ADR_ACCESS:   access_q   <= WRITEDATA;
        ADR_DIR_INFO: dir_info_q <= WRITEDATA;
        ADR_CODE_ST:  codes_q    <= WRITEDATA;
        default:      ;    // unmapped writes are dropped
      endcase
    end
  end

  // a write to the start register latches the decode of the held header
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      ins_q     <= 8'h00;
      known_q   <= 1'b0;
      rsv_op_q  <= 1'b0;
      rsv_adm_q <= 1'b0;
      foreign_q <= 1'b0;
      len_bad_q <= 1'b0;
      code2_q   <= 1'b0;
      dir_q     <= XFER_NONE;
      xfer_q    <= 9'h000;
      offset_q  <= 16'h0000;
    end else if (wr_go && ADDRESS == ADR_DECODE) begin
      foreign_q <= !class_ok;
      if (class_ok) begin // RULE21
        ins_q     <= ins;
        known_q   <= dec_known;
        rsv_op_q  <= dec_rsv_op;
        rsv_adm_q <= dec_rsv_adm;
        len_bad_q <= dec_len_bad;
        dir_q     <= dec_dir;
        xfer_q    <= dec_xfer;
        // unblock addresses codes by 00 and 02, others by 01 and 02
        code2_q   <= (ins == INS_UNBLOCK) ? (p2 == UNBLK_CODE2) : (p2 == CODE2_SEL); // RULE7
        // offset counts body bytes from zero, linear in the two params
        if (ins == INS_RD_BIN || ins == INS_UP_BIN) begin
          offset_q <= {p1, p2}; // RULE1 RULE2
        end
      end
    end
  end

  // sequencer: select gathers two bytes, status and get response stream out
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      state_q   <= ST_IDLE;
      sel_id_q  <= 16'h0000;
      sel_cnt_q <= 1'b0;
      dir_fmt_q <= 1'b1;
      avail_q   <= DIR_RSP_LEN; // root is implicitly selected after reset
      idx_q     <= 5'h00;
      end_q     <= 5'h00;
    end else if (wr_go && ADDRESS == ADR_DECODE && class_ok) begin
      idx_q     <= 5'h00;
      sel_cnt_q <= 1'b0;
      if (ins == INS_SELECT && !dec_len_bad) begin
        state_q <= ST_SEL_RX;
      end else if (ins == INS_STATUS) begin
        dir_fmt_q <= 1'b1; // RULE19
        avail_q   <= DIR_RSP_LEN;
        end_q     <= (dec_xfer > {4'h0, DIR_RSP_LEN}) ? DIR_RSP_LEN : dec_xfer[4:0];
        state_q   <= ST_OUT;
      end else if (ins == INS_GET_RSP && state_q == ST_PENDING) begin
        end_q   <= want;
        state_q <= ST_OUT;
      end else begin
        // any other command drops a pending record
        state_q <= ST_IDLE;
      end
    end else begin
      case (state_q)
        ST_SEL_RX: begin
          if (wr_go && ADDRESS == ADR_SEL_DATA) begin
            sel_cnt_q <= 1'b1;
            sel_id_q  <= {sel_id_q[7:0], WRITEDATA[7:0]};
            if (sel_cnt_q) begin // RULE20
              dir_fmt_q <= (attr_q[7:6] == KIND_DIR);
              avail_q   <= (attr_q[7:6] == KIND_DIR) ? DIR_RSP_LEN : EF_RSP_LEN; // RULE10 RULE16
              state_q   <= ST_PENDING;
            end
          end
        end
        ST_OUT: begin
          if (rd_go && ADDRESS == ADR_RESP) begin
            idx_q <= idx_q + 5'h01;
            if (idx_q + 5'h01 >= end_q) begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_IDLE, ST_PENDING: ;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // builder sees the configured file and the current byte index
  assign rsp.idx      = idx_q;
  assign rsp.dir_fmt  = dir_fmt_q;
  assign rsp.kind     = scd_kind_t'(attr_q[7:6]);
  assign rsp.file_id  = file_id_q[15:0];
  assign rsp.size     = file_id_q[31:16];
  assign rsp.attr     = {attr_q[31:8], 4'h0, attr_q[5:2]};
  assign rsp.access   = access_q;
  assign rsp.dir_info = dir_info_q;
  assign rsp.codes    = codes_q;

  scd_rsp_build u_build (
    .rsp (rsp)
  );

  // read mux; unmapped addresses read zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (ADDRESS)
      ADR_HEADER:   rdata_d = header_q;
      ADR_LENGTH:   rdata_d = {24'h0, length_q};
      ADR_DECODE:   rdata_d = {state_q, 3'h0, xfer_q, ins_q, code2_q, len_bad_q,
                               dir_q, rsv_adm_q, rsv_op_q, known_q, foreign_q};
      ADR_OFFSET:   rdata_d = {3'h0, avail_q, 3'h0, idx_q, offset_q};
      ADR_FILE_ID:  rdata_d = file_id_q;
      ADR_FILE_ATR: rdata_d = attr_q;
      ADR_ACCESS:   rdata_d = access_q;
      ADR_DIR_INFO: rdata_d = dir_info_q;
      ADR_CODE_ST:  rdata_d = codes_q;
      ADR_RESP:     rdata_d = {23'h0, state_q == ST_OUT, rsp.data};
      ADR_SEL_DATA: rdata_d = {16'h0, sel_id_q};
      default:      rdata_d = 32'h0000_0000;
    endcase
  end

  // read data is registered in the wait cycle and stands at the ack edge
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      READDATA <= 32'h0000_0000;
    end else if (READ && !ack_q) begin
      READDATA <= rdata_d;
    end
  end

  // checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  a_wait_one_cycle: assert property (req && !ack_q |=> !WAITREQUEST || !req) // Avalon-MM timing, left to the implementer
    else $error("access not answered after one wait cycle");
  a_foreign_no_change: assert property (wr_go && ADDRESS == ADR_DECODE && !class_ok
    |=> $stable(ins_q) && $stable(state_q)) // RULE21
    else $error("foreign class altered state");
  a_offset_split: assert property (wr_go && ADDRESS == ADR_DECODE && class_ok &&
    ins == INS_RD_BIN |=> offset_q == $past(header_q[15:0])) // RULE1
    else $error("binary offset not taken from params");
  a_zero_len_out: assert property (wr_go && ADDRESS == ADR_DECODE && class_ok &&
    length_q == 8'h00 && dec_dir == XFER_OUT |=> xfer_q == LEN_FULL) // RULE22
    else $error("zero length outward is not 256");
  a_zero_len_in: assert property (wr_go && ADDRESS == ADR_DECODE && class_ok &&
    length_q == 8'h00 && dec_dir == XFER_IN |=> xfer_q == 9'h000) // RULE22
    else $error("zero length inward moved data");
  a_status_dir_fmt: assert property (wr_go && ADDRESS == ADR_DECODE && class_ok &&
    ins == INS_STATUS |=> dir_fmt_q && state_q == ST_OUT) // RULE19
    else $error("status did not use directory layout");
  a_select_two_bytes: assert property (state_q == ST_SEL_RX && wr_go &&
    ADDRESS == ADR_SEL_DATA && !sel_cnt_q |=> state_q == ST_SEL_RX) // RULE20
    else $error("select finished after one byte");
  a_dir_len_22: assert property (state_q == ST_PENDING && dir_fmt_q
    |-> avail_q == DIR_RSP_LEN) // RULE10
    else $error("directory record shorter than 22");
  a_ef_len_15: assert property (state_q == ST_PENDING && !dir_fmt_q
    |-> avail_q == EF_RSP_LEN) // RULE16
    else $error("file record shorter than 15");
  a_unblock_code: assert property (wr_go && ADDRESS == ADR_DECODE && class_ok &&
    ins == INS_UNBLOCK && p2 == UNBLK_CODE1 |=> !code2_q) // RULE7
    else $error("unblock 00 did not pick first code");
  a_rsv_admin: assert property (wr_go && ADDRESS == ADR_DECODE && class_ok &&
    ins == 8'hbc |=> rsv_adm_q && !known_q) // RULE4
    else $error("administrative code not flagged");

  c_select_done: cover property (state_q == ST_SEL_RX ##[1:20] state_q == ST_PENDING);
  c_status_out: cover property (state_q == ST_OUT && rd_go && ADDRESS == ADR_RESP);
  c_get_response: cover property (state_q == ST_PENDING ##[1:20] state_q == ST_OUT);
endmodule

// ==== testbench/scd_hand_model.sv ====
// handset-side avalon master model for the card decoder
`timescale 1ns/10ps
module scd_hand_model (
  input  wire logic        clk,
  input  wire logic        wait_req,
  input  wire logic [31:0] rdata,
  output logic      [5:0]  adr,
  output logic             rd,
  output logic             wr,
  output logic      [31:0] wdata
);
  // bus idle from time zero
  initial begin
    adr = 6'h00;
    rd = 1'b0;
    wr = 1'b0;
    wdata = 32'h0;
  end
  // request held until the rising edge that sees waitrequest low; data taken there
  task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    adr <= a;
    wdata <= d;
    rd <= ~w;
    wr <= w;
    do @(posedge clk); while (wait_req !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    // one idle edge so the next request never re-raises a strobe in this step
    @(posedge clk);
  endtask
endmodule

// ==== testbench/test_sim_command_decode_select_status.sv ====
// self-checking bench for the card command decoder
`timescale 1ns/10ps
module test_sim_command_decode_select_status;
  import scd_pkg::*;
  logic        clk, rst, wreq, rd, wr;
  logic [5:0]  adr;
  logic [7:0]  b, ln;
  logic [2:0]  ed;
  logic [31:0] wd, rdat, q, r, h, lfsr, fid, atr, acs, inf, cst, ofs;
  int          num_errors, n_tests;
  scd_top i_scd_top (.CLOCK(clk), .RST(rst), .ADDRESS(adr), .READ(rd), .WRITE(wr),
    .WRITEDATA(wd), .READDATA(rdat), .WAITREQUEST(wreq));
  scd_hand_model i_scd_hand_model (.clk(clk), .wait_req(wreq), .rdata(rdat), .adr(adr),
    .rd(rd), .wr(wr), .wdata(wd));
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  // {known, direction} per instruction
  function automatic logic [2:0] exp_dir(input logic [7:0] i);
    case (i)
      8'hb0, 8'hb2, 8'hc0, 8'hf2, 8'h12: return 3'h6;
      8'hd6, 8'hdc, 8'h20, 8'h24, 8'h26, 8'h28, 8'h2c, 8'h10, 8'h14: return 3'h5;
      8'ha4, 8'ha2, 8'h32, 8'h88, 8'hc2: return 3'h7;
      8'h04, 8'h44, 8'hfa: return 3'h4;
      default: return 3'h0;
    endcase
  endfunction
  // record byte n (one-based), big-endian multi-byte fields
  function automatic logic [7:0] rec(input logic ef, input int n);
    logic [15:0] sz;
    sz = (ef && atr[7:6] != 2'h1) ? atr[15:8] * atr[23:16] : fid[31:16];
    case (n)
      3: return sz[15:8];
      4: return sz[7:0];
      5: return fid[15:8];
      6: return fid[7:0];
      7: return atr[31:24];
      13: return ef ? EF_FOLLOW : DIR_FOLLOW;
      default: ;
    endcase
    if (ef) case (n)
      8: return (atr[7:6] == 2'h3) ? {1'b0, atr[5], 6'h0} : 8'h0;
      9: return acs[23:16];
      10: return acs[15:8];
      11: return acs[7:0];
      12: return acs[31:24];
      14: return (atr[7:6] == 2'h3) ? STRUCT_CYCLIC :
                 (atr[7:6] == 2'h2) ? STRUCT_LINEAR : STRUCT_TRANSP;
      15: return (atr[7:6] == 2'h1) ? 8'h0 : atr[15:8];
      default: ;
    endcase
    else case (n)
      14: return {inf[31:28], atr[4], atr[3], inf[25], atr[2]};
      15: return inf[7:0];
      16: return inf[15:8];
      17: return inf[23:16];
      19: return cst[31:24];
      20: return cst[23:16];
      21: return cst[15:8];
      22: return cst[7:0];
      default: ;
    endcase
    return 8'h0;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d);
    i_scd_hand_model.acc(w, a, d, q);
  endtask
  // header, length, start, then read back the decode status
  task automatic cmd(input logic [31:0] hd, input logic [7:0] l);
    acc(1'b1, ADR_HEADER, hd);
    acc(1'b1, ADR_LENGTH, {24'h0, l});
    acc(1'b1, ADR_DECODE, 32'h0);
    acc(1'b0, ADR_DECODE, 32'h0);
  endtask
  task automatic end_of_test();
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // hang guard, far beyond the few thousand cycles the run needs
  initial begin
    repeat (30000) @(posedge clk);
    num_errors++;
    end_of_test();
  end
  initial begin
    rst = 1'b1;
    lfsr = 32'h32faa9a7;
    num_errors = 0;
    n_tests = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 256; i++) begin
      r = rnd();
      b = i[7:0];
      h = {CLA_APP, b, r[15:0]};
      if (b == INS_UNBLOCK) h[7:0] = r[16] ? UNBLK_CODE2 : UNBLK_CODE1;
      ln = (i[1:0] == 2'h0) ? 8'h0 : r[31:24];
      if (b == INS_SELECT) ln = LEN_INCREASE;
      ed = exp_dir(b);
      cmd(h, ln);
      chk("decode", {18'h0, b, ed[1:0], b inside {8'h2a, 8'hd0, 8'hd2, 8'hde,
        8'hc4, 8'hc6, 8'hc8, 8'hca, 8'hcc, 8'hb4, 8'hb6, 8'hb8, 8'hba, 8'hbc},
        b[7:4] == 4'h1 && !b[0] && b[3:0] >= 4'h6, ed[2], 1'b0},
        {18'h0, q[15:8], q[5:0]});
      if (b == INS_UNBLOCK) chk("code2", {31'h0, h[1]}, {31'h0, q[7]});
      if (b == INS_SELECT) chk("lenbad", 32'h1, {31'h0, q[6]});
      if (b == INS_RD_BIN || b == INS_UP_BIN) begin
        ofs = h;
        chk("count", {23'h0, ln == 8'h0 && !b[6], ln}, {23'h0, q[24:16]});
        acc(1'b0, ADR_OFFSET, 32'h0);
        chk("offset", {16'h0, h[15:0]}, {16'h0, q[15:0]});
      end
    end
    cmd({8'ha1, INS_UP_BIN, ~ofs[15:0]}, 8'h04);
    chk("foreign", 32'h1, {31'h0, q[0]});
    chk("foreign_ins", 32'hff, {24'h0, q[15:8]});
    acc(1'b0, ADR_OFFSET, 32'h0);
    chk("keep", {16'h0, ofs[15:0]}, {16'h0, q[15:0]});
    acc(1'b0, 6'h3c, 32'h0);
    chk("unmapped", 32'h0, q);
    for (int k = 0; k < 4; k++) begin
      fid = rnd();
      r = rnd();
      atr = {r[31:8], k[1:0], r[5:0]};
      acs = rnd();
      inf = rnd();
      cst = rnd();
      acc(1'b1, ADR_FILE_ID, fid);
      acc(1'b1, ADR_FILE_ATR, atr);
      acc(1'b1, ADR_ACCESS, acs);
      acc(1'b1, ADR_DIR_INFO, inf);
      acc(1'b1, ADR_CODE_ST, cst);
      if (k == 0) cmd({CLA_APP, INS_STATUS, 16'h0}, 8'h0);
      else begin
        cmd({CLA_APP, INS_SELECT, 16'h0}, LEN_SELECT);
        acc(1'b1, ADR_SEL_DATA, {24'h0, fid[15:8]});
        acc(1'b1, ADR_SEL_DATA, {24'h0, fid[7:0]});
        cmd({CLA_APP, INS_GET_RSP, 16'h0}, 8'h0);
      end
      for (int n = 1; n <= ((k == 0) ? 23 : 16); n++) begin
        acc(1'b0, ADR_RESP, 32'h0);
        chk("resp", (n > ((k == 0) ? 22 : 15)) ? 32'h0 : {23'h0, 1'b1, rec(k != 0, n)},
          {23'h0, q[8:0]});
      end
    end
    end_of_test();
  end
endmodule
